/* File: core/cpt_core.sv */
// cpt_core: cpu priority level and trap status registers.
// assumes: trap and event inputs are one-cycle pulses on mclk;
// software reaches the registers over ahb-lite.
//
// Decided for this implementation: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
module cpt_core #(
  parameter int unsigned N_SRC = 4
) (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  reset,
  // ahb-lite register bus
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // cpu core priority updates
  input  wire logic                  core_prio_load,
  input  wire logic [cpt_pkg::PRIO_W-1:0] core_prio_value,
  input  wire logic                  core_trap_enter,
  // accumulator events
  input  wire logic                  acc_a_overflow,
  input  wire logic                  acc_b_overflow,
  input  wire logic                  acc_a_catastrophic,
  input  wire logic                  acc_b_catastrophic,
  // math, dma and system trap events
  input  wire logic                  bad_shift_event,
  input  wire logic                  divide_by_zero_event,
  input  wire logic                  dma_fault_event,
  input  wire logic                  address_trap_event,
  input  wire logic                  stack_trap_event,
  input  wire logic                  oscillator_fail_event,
  // user interrupt requests
  input  wire logic [N_SRC-1:0]      src_req,
  // status outputs
  output logic      [3:0]            cpu_level,
  output logic                       nesting_enabled,
  output logic                       math_trap_pulse,
  output logic                       trap_pending,
  output logic      [N_SRC-1:0]      user_irq_hits,
  output logic                       user_irq_pend
);
  import cpt_pkg::*;

  // map: one word each
  // status: field only
  // core: fourth bit only
  // intctl: nest, enables,
  // sticky flags
  // srcprio: 3 bits each
  // others read zero

  localparam int unsigned SP_W = N_SRC * PRIO_W; // source priority bits

  // level is split: field
  // in status, high bit in
  // core control
  // both clear on reset

  // register state
  logic [PRIO_W-1:0] cpu_priority_field;     // level bits 2..0
  logic              cpu_priority_high_bit;  // level bit 3
  logic              nesting_disable;        // blocks field writes
  logic              acc_a_overflow_trap_en; // overflow a enable
  logic              acc_b_overflow_trap_en; // overflow b enable
  logic              catastrophic_trap_en;   // catastrophic enable
  logic [SP_W-1:0]   src_prio;               // per-source levels
  logic [15:0]       flags;                  // sticky trap flags

  // wr is one cycle; addr
  // holds through a read

  // register access port
  cpt_reg_if rif ();

  // haddr above bit 7 is
  // not decoded: the map
  // repeats each 256 bytes

  // decoded write strobes
  wire wr_status;
  wire wr_core;
  wire wr_intctl;
  wire wr_srcprio;
  assign wr_status  = rif.wr & (rif.addr == OFF_STATUS);
  assign wr_core    = rif.wr & (rif.addr == OFF_CORE);
  assign wr_intctl  = rif.wr & (rif.addr == OFF_INTCTL);
  assign wr_srcprio = rif.wr & (rif.addr == OFF_SRCPRIO);

  // a disabled overflow
  // is dropped here: no
  // flag, no math flag

  // gated trap causes
  wire ova_trap;
  wire ovb_trap;
  wire cova_trap;
  wire covb_trap;
  wire math_any;
  // ordinary overflow only traps while its enable is set
  assign ova_trap  = acc_a_overflow & acc_a_overflow_trap_en;
  assign ovb_trap  = acc_b_overflow & acc_b_overflow_trap_en;
  // catastrophic overflow shares one enable
  assign cova_trap = acc_a_catastrophic & catastrophic_trap_en;
  assign covb_trap = acc_b_catastrophic & catastrophic_trap_en;
  // every accumulator or arithmetic trap is a math trap
  assign math_any = ova_trap | ovb_trap | cova_trap | covb_trap
                  | bad_shift_event | divide_by_zero_event;

  // unsourced bits stay 0:
  // enables and bit 0 are
  // never set by hardware

  // hardware set vector for the sticky flags
  logic [15:0] flag_set;
  always_comb begin
    flag_set              = REG_RST;
    flag_set[B_OVA_FLAG]  = ova_trap;
    flag_set[B_OVB_FLAG]  = ovb_trap;
    flag_set[B_COVA_FLAG] = cova_trap;
    flag_set[B_COVB_FLAG] = covb_trap;
    flag_set[B_SHIFT]     = bad_shift_event;
    flag_set[B_DIV0]      = divide_by_zero_event;
    flag_set[B_DMA]       = dma_fault_event;
    flag_set[B_MATH]      = math_any;
    flag_set[B_ADDR]      = address_trap_event;
    flag_set[B_STACK]     = stack_trap_event;
    flag_set[B_OSC]       = oscillator_fail_event;
  end

  // hazard: read-modify-
  // write of this word can
  // clear a flag set in
  // between; write 1s to
  // flags to keep them

  // software clears a flag by writing zero to it; ones are ignored
  wire [15:0] flag_clr;
  assign flag_clr = {16{wr_intctl}} & ~rif.wdata & FLAG_MASK;

  // flag bank; bit 0 and control bits never set, masked on read
  cpt_sticky #(
    .W (16)
  ) u_flags (
    .mclk  (mclk),
    .reset (reset),
    .set   (flag_set),
    .clr   (flag_clr),
    .q     (flags)
  );

  // writes: no wait state
  // reads: one, so hrdata
  // comes from a flop
  // hsize is ignored

  // bus front end
  cpt_ahb_slave u_bus (
    .mclk      (mclk),
    .reset     (reset),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .rif       (rif.bus)
  );

  // trade-off: a core load
  // beats a software write
  // in the same cycle; the
  // core knows the level
  // it actually runs at

  // priority field: the core reloads it when it takes an interrupt
  // or returns; software may write it only while nesting is allowed
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cpu_priority_field <= PRIO_RST;
    end else if (core_prio_load) begin
      cpu_priority_field <= core_prio_value;
    end else if (wr_status && !nesting_disable) begin
      cpu_priority_field <= rif.wdata[PRIO_LSB +: PRIO_W];
    end
  end

  // a written 1 is ignored
  // so user code can never
  // mask a trap

  // fourth bit: set by trap entry only, software may only clear it;
  // a trap entry in the same cycle as the clear keeps it set
  wire high_clr;
  assign high_clr = wr_core & ~rif.wdata[HIGH_BIT];
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cpu_priority_high_bit <= 1'b0;
    end else if (core_trap_enter) begin
      cpu_priority_high_bit <= 1'b1;
    end else if (high_clr) begin
      cpu_priority_high_bit <= 1'b0;
    end
  end

  // an enable acts on later
  // events only; a set flag
  // stays when it drops

  // interrupt control one: nesting and trap enables
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      nesting_disable        <= 1'b0;
      acc_a_overflow_trap_en <= 1'b0;
      acc_b_overflow_trap_en <= 1'b0;
      catastrophic_trap_en   <= 1'b0;
    end else if (wr_intctl) begin
      nesting_disable        <= rif.wdata[B_NEST_DIS];
      acc_a_overflow_trap_en <= rif.wdata[B_OVA_EN];
      acc_b_overflow_trap_en <= rif.wdata[B_OVB_EN];
      catastrophic_trap_en   <= rif.wdata[B_COV_EN];
    end
  end

  // level 0 never beats the
  // cpu: it parks a source
  // 7 beats all below 7

  // per-source priority levels, three bits each
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      src_prio <= '0;
    end else if (wr_srcprio) begin
      src_prio <= rif.wdata[SP_W-1:0];
    end
  end

  // reads as 8 plus field
  // while the high bit is 1
  // (levels 8 to 15)

  // effective level, fourth bit above the field
  wire [3:0] level;
  assign level = {cpu_priority_high_bit, cpu_priority_field};

  // limitation: no
  // arbitration here; all
  // winners show at once

  // a source wins when its level beats the cpu level; with the
  // fourth bit set no three-bit level can win, so all are held off
  wire [N_SRC-1:0] src_hit;
  genvar s;
  generate
    for (s = 0; s < N_SRC; s++) begin : g_src
      wire [3:0] lvl;
      assign lvl = {1'b0, src_prio[s*PRIO_W +: PRIO_W]};
      assign src_hit[s] = src_req[s] & (lvl > level)
                        & ~cpu_priority_high_bit;
    end
  endgenerate

  // outputs lag state by
  // one cycle; the math
  // pulse is one cycle long

  // registered status outputs
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cpu_level       <= 4'h0;
      nesting_enabled <= 1'b1;
      math_trap_pulse <= 1'b0;
      trap_pending    <= 1'b0;
      user_irq_hits   <= '0;
      user_irq_pend   <= 1'b0;
    end else begin
      cpu_level       <= level;
      nesting_enabled <= ~nesting_disable;
      math_trap_pulse <= math_any;
      trap_pending    <= |(flags & FLAG_MASK);
      user_irq_hits   <= src_hit;
      user_irq_pend   <= |src_hit;
    end
  end

  // reads have no side
  // effects; only writes
  // clear flags
  // bit 0 reads 0

  // read views of each register; unlisted bits read zero
  wire [15:0] rd_status;
  wire [15:0] rd_core;
  wire [15:0] rd_intctl;
  wire [15:0] rd_srcprio;
  assign rd_status = {8'h00, cpu_priority_field, 5'h00};
  assign rd_core   = {12'h000, cpu_priority_high_bit, 3'h0};
  // bit 0 is never set and is masked out besides
  assign rd_intctl = (flags & FLAG_MASK)
                   | ({15'h0000, nesting_disable} << B_NEST_DIS)
                   | ({15'h0000, acc_a_overflow_trap_en} << B_OVA_EN)
                   | ({15'h0000, acc_b_overflow_trap_en} << B_OVB_EN)
                   | ({15'h0000, catastrophic_trap_en} << B_COV_EN);
  assign rd_srcprio = 16'(src_prio);

  // addr is the captured
  // word address, steady
  // through the wait

  // read select; unmapped addresses read zero
  assign rif.rdata = (rif.addr == OFF_STATUS)  ? rd_status  :
                     (rif.addr == OFF_CORE)    ? rd_core    :
                     (rif.addr == OFF_INTCTL)  ? rd_intctl  :
                     (rif.addr == OFF_SRCPRIO) ? rd_srcprio :
                     REG_RST;

endmodule // cpt_core

/* File: core/cpt_pkg.sv */
// cpt_pkg: shared constants of the cpu priority and trap status block.
// assumes: included before any other file of the block.
package cpt_pkg;
  // register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned REG_W  = 16;
  // word offsets on the register bus
  localparam logic [7:0] OFF_STATUS  = 8'h00;
  localparam logic [7:0] OFF_CORE    = 8'h04;
  localparam logic [7:0] OFF_INTCTL  = 8'h08;
  localparam logic [7:0] OFF_SRCPRIO = 8'h0C;
  // reset value of every register
  localparam logic [15:0] REG_RST = 16'h0000;
  // cpu status word: priority field
  localparam int unsigned PRIO_W   = 3;
  localparam int unsigned PRIO_LSB = 5;
  localparam logic [2:0]  PRIO_RST = 3'h0;
  // core control word: fourth priority bit
  localparam int unsigned HIGH_BIT = 3;
  // interrupt control one: bit positions
  localparam int unsigned B_NEST_DIS  = 15;
  localparam int unsigned B_OVA_FLAG  = 14;
  localparam int unsigned B_OVB_FLAG  = 13;
  localparam int unsigned B_COVA_FLAG = 12;
  localparam int unsigned B_COVB_FLAG = 11;
  localparam int unsigned B_OVA_EN    = 10;
  localparam int unsigned B_OVB_EN    = 9;
  localparam int unsigned B_COV_EN    = 8;
  localparam int unsigned B_SHIFT     = 7;
  localparam int unsigned B_DIV0      = 6;
  localparam int unsigned B_DMA       = 5;
  localparam int unsigned B_MATH      = 4;
  localparam int unsigned B_ADDR      = 3;
  localparam int unsigned B_STACK     = 2;
  localparam int unsigned B_OSC       = 1;
  // sticky flag bits of interrupt control one
  localparam logic [15:0] FLAG_MASK = 16'h78FE;
  // bus response and transfer type
  localparam logic        HRESP_OKAY = 1'b0;
  localparam int unsigned HTRANS_ACT = 1;
  // bus slave states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_WRITE = 4'b0010,
    ST_RWAIT = 4'b0100,
    ST_RDONE = 4'b1000
  } cpt_bus_e;
endpackage

/* File: core/cpt_reg_if.sv */
// cpt_reg_if: register access between the bus slave and the register core.
// assumes: one clock domain; wr is a one-cycle strobe.
`timescale 1ns/10ps
interface cpt_reg_if;
  logic        wr;    // write strobe
  logic [7:0]  addr;  // word address
  logic [15:0] wdata; // write data
  logic [15:0] rdata; // read data of addr
  modport bus  (output wr, output addr, output wdata, input rdata);
  modport regs (input wr, input addr, input wdata, output rdata);
endinterface

/* File: core/cpt_sticky.sv */
// cpt_sticky: bank of sticky flags, set by hardware, cleared by software.
// assumes: set and clr are synchronous one-cycle levels.
`timescale 1ns/10ps
module cpt_sticky #(
  parameter int unsigned W = 16
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         reset,
  // set and clear per bit
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  // flags
  output logic      [W-1:0] q
);
  genvar i;
  // one flop per flag; set beats clear in the same cycle
  generate
    for (i = 0; i < W; i++) begin : g_flag
      always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
          q[i] <= 1'b0;
        end else if (set[i]) begin
          q[i] <= 1'b1;
        end else if (clr[i]) begin
          q[i] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule // cpt_sticky

/* File: core/cpt_ahb_slave.sv */
// cpt_ahb_slave: ahb-lite slave front end, one word per register.
// assumes: single transfers of whole words; hready is our hreadyout.
`timescale 1ns/10ps
module cpt_ahb_slave (
  // clock and reset
  input  wire logic                          mclk,
  input  wire logic                          reset,
  // ahb-lite
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic      [31:0]                   hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  // register side
  cpt_reg_if.bus                             rif
);
  import cpt_pkg::*;
  cpt_bus_e   state;      // data phase tracker
  cpt_bus_e   next_state; // its next value
  logic [7:0] addr_q;     // captured word address
  wire        addr_ph;    // valid address phase
  // a transfer is taken when selected, active and the bus is ready
  assign addr_ph = hsel & hready & htrans[HTRANS_ACT];
  // reads insert one wait state so hrdata comes from a flop
  assign hreadyout = (state != ST_RWAIT);
  assign hresp     = HRESP_OKAY;
  assign rif.wr    = (state == ST_WRITE);
  assign rif.addr  = addr_q;
  assign rif.wdata = hwdata[15:0];
  // next state of the data phase
  always_comb begin
    case (state)
      ST_RWAIT: next_state = ST_RDONE;
      ST_IDLE, ST_WRITE, ST_RDONE: begin
        if (addr_ph) begin
          next_state = hwrite ? ST_WRITE : ST_RWAIT;
        end else begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end
  // state, address capture and read data
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state  <= ST_IDLE;
      addr_q <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      state <= next_state;
      if (addr_ph) addr_q <= haddr[7:0];
      if (state == ST_RWAIT) hrdata <= {16'h0000, rif.rdata};
    end
  end
endmodule // cpt_ahb_slave

/* File: test/cpt_core_monitor.sv */
// cpt_core_monitor: port-level assertions for cpt_core.
// assumes: bound to cpt_core; one clock domain, mclk.
`timescale 1ns/10ps
module cpt_core_monitor #(
  parameter int unsigned N_SRC = 4
) (
  // clock and reset
  input wire logic                       mclk,
  input wire logic                       reset,
  // bus
  input wire logic                       hsel,
  input wire logic [1:0]                 htrans,
  input wire logic                       hwrite,
  input wire logic                       hready,
  input wire logic                       hreadyout,
  input wire logic                       hresp,
  // core and events
  input wire logic                       core_prio_load,
  input wire logic [cpt_pkg::PRIO_W-1:0] core_prio_value,
  input wire logic                       core_trap_enter,
  input wire logic                       acc_a_overflow,
  input wire logic                       acc_b_overflow,
  input wire logic                       acc_a_catastrophic,
  input wire logic                       acc_b_catastrophic,
  input wire logic                       bad_shift_event,
  input wire logic                       divide_by_zero_event,
  input wire logic                       dma_fault_event,
  input wire logic                       address_trap_event,
  input wire logic                       stack_trap_event,
  input wire logic                       oscillator_fail_event,
  // status
  input wire logic [3:0]                 cpu_level,
  input wire logic                       math_trap_pulse,
  input wire logic                       trap_pending,
  input wire logic [N_SRC-1:0]           user_irq_hits,
  input wire logic                       user_irq_pend
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // any math-class or system-class event
  wire any_math = acc_a_overflow | acc_b_overflow | acc_a_catastrophic
                | acc_b_catastrophic | bad_shift_event | divide_by_zero_event;
  wire any_sys  = dma_fault_event | address_trap_event | stack_trap_event
                | oscillator_fail_event;
  // taken transfers
  wire rd_req   = hsel & hready & htrans[1] & !hwrite;
  wire wr_req   = hsel & hready & htrans[1] & hwrite;

  property p_math; bad_shift_event || divide_by_zero_event |=> math_trap_pulse; endproperty
  a_math: assert property (p_math) else $error("no math pulse");
  property p_math_cause; math_trap_pulse |-> $past(any_math); endproperty
  a_math_cause: assert property (p_math_cause) else $error("math pulse without cause");
  property p_sys; any_sys |-> ##2 trap_pending; endproperty
  a_sys: assert property (p_sys) else $error("trap not pending");
  property p_enter; core_trap_enter |-> ##2 cpu_level[3]; endproperty
  a_enter: assert property (p_enter) else $error("fourth bit not set");
  property p_rise; $rose(cpu_level[3]) |-> $past(core_trap_enter, 2); endproperty
  a_rise: assert property (p_rise) else $error("fourth bit set by other cause");
  property p_load; core_prio_load |-> ##2
    (cpu_level[2:0] == $past(core_prio_value, 2)); endproperty
  a_load: assert property (p_load) else $error("priority field not loaded");
  property p_block; cpu_level[3] |-> user_irq_hits == '0; endproperty
  a_block: assert property (p_block) else $error("user irq while blocked");
  property p_pend; user_irq_pend == (|user_irq_hits); endproperty
  a_pend: assert property (p_pend) else $error("pend disagrees with hits");
  property p_clear; $fell(trap_pending) |-> $past(wr_req, 3); endproperty
  a_clear: assert property (p_clear) else $error("flags fell without write");
  property p_okay; hresp == cpt_pkg::HRESP_OKAY; endproperty
  a_okay: assert property (p_okay) else $error("bad response");
  property p_rwait; rd_req |=> !hreadyout ##1 hreadyout; endproperty
  a_rwait: assert property (p_rwait) else $error("read wait wrong");
endmodule // cpt_core_monitor

bind cpt_core cpt_core_monitor #(.N_SRC(N_SRC)) u_mon (
  .mclk(mclk), .reset(reset), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .core_prio_load(core_prio_load), .core_prio_value(core_prio_value),
  .core_trap_enter(core_trap_enter), .acc_a_overflow(acc_a_overflow),
  .acc_b_overflow(acc_b_overflow), .acc_a_catastrophic(acc_a_catastrophic),
  .acc_b_catastrophic(acc_b_catastrophic), .bad_shift_event(bad_shift_event),
  .divide_by_zero_event(divide_by_zero_event), .dma_fault_event(dma_fault_event),
  .address_trap_event(address_trap_event), .stack_trap_event(stack_trap_event),
  .oscillator_fail_event(oscillator_fail_event), .cpu_level(cpu_level),
  .math_trap_pulse(math_trap_pulse), .trap_pending(trap_pending),
  .user_irq_hits(user_irq_hits), .user_irq_pend(user_irq_pend));

/* File: test/cpt_trap_model.sv */
// cpt_trap_model: cpu core and trap sources facing cpt_core.
// assumes: fire bits are held by the bench for one cycle each.
`timescale 1ns/10ps
module cpt_trap_model (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // requests from the bench
  input  wire logic [11:0] fire,
  input  wire logic [2:0]  pval,
  // toward the block
  output logic      [9:0]  ev,
  output logic             trap_enter,
  output logic             prio_load,
  output logic      [2:0]  prio_value
);
  // one-cycle pulses; value wanders when not loading, so stale data shows
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ev         <= '0;
      trap_enter <= 1'b0;
      prio_load  <= 1'b0;
      prio_value <= 3'h0;
    end else begin
      ev         <= fire[9:0];
      trap_enter <= fire[10];
      prio_load  <= fire[11];
      prio_value <= fire[11] ? pval : ~prio_value;
    end
  end
endmodule // cpt_trap_model

/* File: test/tb_top.sv */
// tb_top: self-checking bench for cpt_core over ahb-lite.
// assumes: cpt_trap_model drives the events; reads are checked from a queue.
`timescale 1ns/10ps
module tb_top;
  import cpt_pkg::*;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = '0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic [11:0] fire = '0;
  logic [2:0]  pval = '0;
  logic [3:0]  src_req = '0;
  logic [9:0]  ev;
  logic        t_ent;
  logic        p_ld;
  logic [2:0]  p_val;
  logic [3:0]  cpu_level;
  logic [3:0]  hits;
  logic        nest;
  logic        pend;
  logic        tpend;
  logic [31:0] exp_q[$];
  logic        rd_pend = 1'b0;
  int          err_total = 0;
  int          num_checks = 0;
  logic [31:0] rs = 32'h0000_0620;
  logic [15:0] en;
  logic [3:0]  e;
  logic        gate;
  logic [15:0] flag_tab [10] = '{16'h4010, 16'h2010, 16'h1010, 16'h0810, 16'h0090,
                                 16'h0050, 16'h0020, 16'h0008, 16'h0004, 16'h0002};
  always #10 mclk = ~mclk;

  cpt_core #(.N_SRC(4)) dut (
    .mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
    .core_prio_load(p_ld), .core_prio_value(p_val), .core_trap_enter(t_ent),
    .acc_a_overflow(ev[0]), .acc_b_overflow(ev[1]), .acc_a_catastrophic(ev[2]),
    .acc_b_catastrophic(ev[3]), .bad_shift_event(ev[4]), .divide_by_zero_event(ev[5]),
    .dma_fault_event(ev[6]), .address_trap_event(ev[7]), .stack_trap_event(ev[8]),
    .oscillator_fail_event(ev[9]), .src_req(src_req), .cpu_level(cpu_level),
    .nesting_enabled(nest), .math_trap_pulse(), .trap_pending(tpend),
    .user_irq_hits(hits), .user_irq_pend(pend));
  cpt_trap_model u_far (.mclk(mclk), .reset(reset), .fire(fire), .pval(pval), .ev(ev),
    .trap_enter(t_ent), .prio_load(p_ld), .prio_value(p_val));

  task automatic report_and_stop;
    if (err_total == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, x, g);
    end
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // bounded wait for hready high at an edge
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      err_total++;
      report_and_stop();
    end
  endtask
  // one single transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {16'h0, d};
    wait_rdy();
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] x);
    exp_q.push_back({16'h0, x});
    bus(1'b0, a, ~x);
  endtask
  task automatic pulse(input logic [11:0] m);
    fire <= m;
    @(posedge mclk);
    fire <= '0;
  endtask

  // watcher: each finished read is matched with the oldest note
  always @(posedge mclk) begin
    if (rd_pend && hreadyout === 1'b1) begin
      rd_pend = 1'b0;
      if (exp_q.size() == 0) chk("read queue", 32'h1, 32'h0);
      else chk("hrdata", exp_q.pop_front(), hrdata);
    end
    if (hsel && hreadyout && htrans[1] && !hwrite) rd_pend = 1'b1;
  end

  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 5; i++) rd(8'(4 * i), 16'h0000);
    chk("nest", 32'h1, {31'h0, nest});
    chk("pending", 32'h0, {31'h0, tpend});
    wr(OFF_STATUS, 16'hFFFF);
    rd(OFF_STATUS, 16'h00E0);
    wr(OFF_STATUS, 16'h00A0);
    wr(OFF_INTCTL, 16'h8000);
    wr(OFF_STATUS, 16'h0060);
    rd(OFF_STATUS, 16'h00A0);
    chk("level", 32'h5, {28'h0, cpu_level});
    chk("nest", 32'h0, {31'h0, nest});
    // core load is not blocked by nesting off
    pval <= 3'h3;
    pulse(12'h800);
    cyc(2);
    rd(OFF_STATUS, 16'h0060);
    wr(OFF_INTCTL, 16'h0000);
    wr(OFF_CORE, 16'hFFFF);
    rd(OFF_CORE, 16'h0000);
    src_req <= 4'hF;
    wr(OFF_SRCPRIO, 16'h0FFF);
    pulse(12'h400);
    cyc(2);
    rd(OFF_CORE, 16'h0008);
    chk("level", 32'hB, {28'h0, cpu_level});
    chk("hits", 32'h0, {28'h0, hits});
    wr(OFF_CORE, 16'h0000);
    rd(OFF_CORE, 16'h0000);
    chk("hits", 32'hF, {28'h0, hits});
    // every event under each single enable and with all enables off
    for (int k = 0; k < 4; k++) begin
      en = (k == 3) ? 16'h0000 : (16'h0100 << k);
      for (int i = 0; i < 10; i++) begin
        wr(OFF_INTCTL, en);
        pulse(12'(1 << i));
        cyc(1);
        gate = (i == 0) ? en[10] : (i == 1) ? en[9] : (i < 4) ? en[8] : 1'b1;
        rd(OFF_INTCTL, en | (gate ? flag_tab[i] : 16'h0));
      end
    end
    wr(OFF_INTCTL, 16'hFFFF);
    rd(OFF_INTCTL, 16'h8702);
    wr(OFF_INTCTL, 16'h0000);
    // a set landing with a clear survives it
    pulse(12'h080);
    cyc(1);
    fork
      pulse(12'h040);
      wr(OFF_INTCTL, 16'h0000);
    join
    rd(OFF_INTCTL, 16'h0020);
    chk("pending", 32'h1, {31'h0, tpend});
    // random source priorities against the cpu level
    for (int j = 0; j < 8; j++) begin
      rs = lfsr(rs);
      wr(OFF_SRCPRIO, {4'h0, rs[11:0]});
      wr(OFF_STATUS, {8'h0, rs[18:16], 5'h0});
      src_req <= rs[15:12];
      cyc(2);
      for (int i = 0; i < 4; i++) e[i] = rs[12 + i] && (rs[3 * i +: 3] > rs[18:16]);
      chk("hits", {28'h0, e}, {28'h0, hits});
      chk("pend", {31'h0, |e}, {31'h0, pend});
      rd(OFF_SRCPRIO, {4'h0, rs[11:0]});
    end
    report_and_stop();
  end
endmodule // tb_top
